/* rtl/mii_transmit_collision_mac.sv */
// Transmit side of a 10/100 MAC: frame buffer, MII nibble transmitter,
// half-duplex collision retry and full-duplex collision-pin flow stop.
// Assumes the PHY drives a free-running nibble clock; frames carry their FCS.
// Function
// - PHY supplies 25 or 2.5 MHz transmit clock
// - data and enable timed by transmit clock
// - transmit error output always low
// - four data lines, line zero least significant
// - data meaningful only while enable high
// - enable high exactly for frame nibbles
// - collision input resynchronised before any use
// - full duplex collision means flow stop
// - no new packet while flow stop high
// - started packet completes despite flow stop
// - full and half duplex at both rates
// - transmit DMA request when buffer empty
// - receive DMA request on packet received
`timescale 1ns/1ps
module mii_transmit_collision_mac
  import mtcm_pkg::*;
(
  // system clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // configuration
  input wire logic i_full_duplex,
  // frame byte stream in
  input wire mtcm_byte_t i_frame,
  input wire logic i_frame_valid,
  output logic o_frame_ready,
  // frame completion
  output logic o_frame_sent,
  output logic o_frame_aborted,
  // DMA requests
  output logic o_tx_dma_req,
  input wire logic i_rx_packet_received,
  output logic o_rx_dma_req,
  // MII transmit pins
  input wire logic i_tx_nibble_clock,
  input wire logic i_collision_or_flow_stop,
  output mtcm_mii_tx_t o_mii_tx
);

  ////////////////////////////////////////////////////////////////////////////
  // system domain: frame buffer
  logic [7:0] tx_buf [BUF_DEPTH];
  logic [BUF_ADDR_W-1:0] wptr;
  logic [BUF_ADDR_W-1:0] last_idx;
  logic busy, go_toggle, done_sys, done_seen, done_edge, accept, abort_flag, done_toggle;

  assign o_frame_ready = !busy;
  assign accept = i_frame_valid && !busy;
  assign done_edge = done_sys != done_seen;
  // buffer free and nothing loaded yet
  assign o_tx_dma_req = !busy && (wptr == BUF_FIRST_ADDR);

  // buffer contents stay still while busy, so the link side reads them freely
  always_ff @(posedge i_clock) begin
    if (accept) begin
      tx_buf[wptr] <= i_frame.data;
    end
  end

  // a frame longer than the buffer is cut at the last address
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      wptr <= BUF_FIRST_ADDR;
      last_idx <= BUF_FIRST_ADDR;
      busy <= 1'b0;
      go_toggle <= 1'b0;
    end else if (done_edge) begin
      busy <= 1'b0;
      wptr <= BUF_FIRST_ADDR;
    end else if (accept) begin
      if (i_frame.last || (wptr == BUF_LAST_ADDR)) begin
        last_idx <= wptr;
        busy <= 1'b1;
        go_toggle <= !go_toggle;
        wptr <= BUF_FIRST_ADDR;
      end else begin
        wptr <= 11'(wptr + 11'h001);
      end
    end
  end

  mtcm_sync #(
    .WIDTH(1)
  ) u_done_sync (
    .i_clock(i_clock),
    .i_async(done_toggle),
    .o_sync(done_sys)
  );

  // abort flag is held by the link until the next frame starts
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      done_seen <= 1'b0;
      o_frame_sent <= 1'b0;
      o_frame_aborted <= 1'b0;
    end else begin
      done_seen <= done_sys;
      o_frame_sent <= done_edge && !abort_flag;
      o_frame_aborted <= done_edge && abort_flag;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rx_dma_req <= 1'b0;
    end else begin
      o_rx_dma_req <= i_rx_packet_received;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: crossings
  logic link_rst_n, fd_s, go_s, col_s;

  mtcm_sync #(
    .WIDTH(4)
  ) u_link_sync (
    .i_clock(i_tx_nibble_clock),
    .i_async({i_reset_n, i_full_duplex, go_toggle, i_collision_or_flow_stop}),
    .o_sync({link_rst_n, fd_s, go_s, col_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // link domain: transmitter
  mtcm_link_state_t state, next_state;
  logic [11:0] cnt, next_cnt, nib_index;
  mtcm_mii_tx_t mii_tx, next_tx;
  logic go_taken, go_pending, retry, hd_collision;
  logic [4:0] attempts, limit;
  logic [9:0] slots;
  logic [15:0] lfsr;
  logic [7:0] rd_byte;
  logic [3:0] rd_nibble;
  logic [10:0] mask_wide;

  assign o_mii_tx = mii_tx;
  assign go_pending = go_s != go_taken;
  // half duplex: collision held by PHY for as long as it lasts
  assign hd_collision = !fd_s && col_s;
  assign nib_index = (state == LS_DATA) ? 12'(cnt + 12'h001) : CNT_ZERO;
  assign rd_byte = tx_buf[nib_index[11:1]];
  // low nibble first, bit 0 on line 0
  assign rd_nibble = nib_index[0] ? rd_byte[7:4] : rd_byte[3:0];
  assign limit = (attempts > BACKOFF_LIMIT) ? BACKOFF_LIMIT : attempts;
  assign mask_wide = 11'((11'h001 << limit) - 11'h001);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_tx = mii_tx;
    next_tx.tx_error_out = 1'b0;
    case (state)
      LS_IDLE: begin
        next_tx.tx_nibble_enable = 1'b0;
        next_tx.tx_nibble_data = IDLE_NIBBLE;
        // flow stop only blocks a start, never a frame in flight
        if (go_pending && !(fd_s && col_s)) begin
          next_state = LS_PREAMBLE;
          next_cnt = CNT_ZERO;
          next_tx.tx_nibble_enable = 1'b1;
          next_tx.tx_nibble_data = PREAMBLE_NIBBLE;
        end
      end
      LS_PREAMBLE, LS_DATA: begin
        if (hd_collision) begin
          next_state = LS_JAM;
          next_cnt = CNT_ZERO;
          next_tx.tx_nibble_data = JAM_NIBBLE;
        end else if (state == LS_PREAMBLE && cnt == PREAMBLE_LAST_CNT) begin
          next_state = LS_DATA;
          next_cnt = CNT_ZERO;
          next_tx.tx_nibble_data = rd_nibble;
        end else if (state == LS_PREAMBLE) begin
          next_cnt = 12'(cnt + 12'h001);
          next_tx.tx_nibble_data =
            (next_cnt == PREAMBLE_LAST_CNT) ? SFD_NIBBLE : PREAMBLE_NIBBLE;
        end else if (cnt == {last_idx, 1'b1}) begin
          next_state = LS_GAP;
          next_cnt = CNT_ZERO;
          next_tx.tx_nibble_enable = 1'b0;
          next_tx.tx_nibble_data = IDLE_NIBBLE;
        end else begin
          next_cnt = 12'(cnt + 12'h001);
          next_tx.tx_nibble_data = rd_nibble;
        end
      end
      LS_JAM: begin
        if (cnt == JAM_LAST_CNT) begin
          next_state = (attempts >= MAX_ATTEMPTS) ? LS_GAP : LS_BACKOFF;
          next_cnt = CNT_ZERO;
          next_tx.tx_nibble_enable = 1'b0;
          next_tx.tx_nibble_data = IDLE_NIBBLE;
        end else begin
          next_cnt = 12'(cnt + 12'h001);
        end
      end
      LS_BACKOFF: begin
        if (slots == 10'h000) begin
          next_state = LS_GAP;
          next_cnt = CNT_ZERO;
        end else if (cnt == SLOT_LAST_CNT) begin
          next_cnt = CNT_ZERO;
        end else begin
          next_cnt = 12'(cnt + 12'h001);
        end
      end
      LS_GAP: begin
        if (cnt == GAP_LAST_CNT && retry) begin
          next_state = LS_PREAMBLE;
          next_cnt = CNT_ZERO;
          next_tx.tx_nibble_enable = 1'b1;
          next_tx.tx_nibble_data = PREAMBLE_NIBBLE;
        end else if (cnt == GAP_LAST_CNT) begin
          next_state = LS_IDLE;
          next_cnt = CNT_ZERO;
        end else begin
          next_cnt = 12'(cnt + 12'h001);
        end
      end
      default: begin
        next_state = LS_IDLE;
        next_cnt = CNT_ZERO;
        next_tx = '0;
      end
    endcase
  end

  // pins change only on the PHY's nibble clock
  always_ff @(posedge i_tx_nibble_clock) begin
    if (!link_rst_n) begin
      state <= LS_IDLE;
      cnt <= CNT_ZERO;
      mii_tx <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mii_tx <= next_tx;
    end
  end

  // attempt count, retry and abort bookkeeping
  always_ff @(posedge i_tx_nibble_clock) begin
    if (!link_rst_n) begin
      go_taken <= 1'b0;
      attempts <= 5'h00;
      retry <= 1'b0;
      abort_flag <= 1'b0;
      done_toggle <= 1'b0;
    end else begin
      if (state == LS_IDLE && next_state == LS_PREAMBLE) begin
        go_taken <= go_s;
        attempts <= 5'h00;
        abort_flag <= 1'b0;
        retry <= 1'b0;
      end else if (state != LS_JAM && next_state == LS_JAM) begin
        attempts <= 5'(attempts + 5'h01);
      end else if (state == LS_JAM && next_state == LS_GAP) begin
        abort_flag <= 1'b1;
      end else if (state == LS_BACKOFF && next_state == LS_GAP) begin
        retry <= 1'b1;
      end else if (state == LS_GAP && next_state == LS_PREAMBLE) begin
        retry <= 1'b0;
      end else if (state == LS_GAP && next_state == LS_IDLE) begin
        done_toggle <= !done_toggle;
      end
    end
  end

  // truncated binary exponential backoff slot count
  always_ff @(posedge i_tx_nibble_clock) begin
    if (!link_rst_n) begin
      slots <= 10'h000;
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      if (state == LS_JAM && next_state == LS_BACKOFF) begin
        slots <= lfsr[9:0] & mask_wide[9:0];
      end else if (state == LS_BACKOFF && cnt == SLOT_LAST_CNT && slots != 10'h000) begin
        slots <= 10'(slots - 10'h001);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // pin reset covers the first link edges, before its synchronised copy is known
  property p_err_low;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      !o_mii_tx.tx_error_out;
  endproperty
  a_err_low: assert property (p_err_low) else $error("tx error output not low");
  property p_en_frame;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      o_mii_tx.tx_nibble_enable == (state inside {LS_PREAMBLE, LS_DATA, LS_JAM});
  endproperty
  a_en_frame: assert property (p_en_frame) else $error("enable outside frame nibbles");
  property p_sfd;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      (state == LS_PREAMBLE && cnt == PREAMBLE_LAST_CNT) |-> o_mii_tx.tx_nibble_data == SFD_NIBBLE;
  endproperty
  a_sfd: assert property (p_sfd) else $error("delimiter nibble wrong");
  property p_lsb;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      (state == LS_DATA && cnt == CNT_ZERO) |-> o_mii_tx.tx_nibble_data == tx_buf[0][3:0];
  endproperty
  a_lsb: assert property (p_lsb) else $error("first data nibble not low nibble");
  property p_col_sync;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      col_s == $past(i_collision_or_flow_stop, 2);
  endproperty
  a_col_sync: assert property (p_col_sync) else $error("collision sync depth wrong");
  property p_fd_hold;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      (state == LS_IDLE && fd_s && col_s) |=> state == LS_IDLE && !o_mii_tx.tx_nibble_enable;
  endproperty
  a_fd_hold: assert property (p_fd_hold) else $error("start during flow stop");
  property p_fd_finish;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      (state == LS_DATA && fd_s) |=> state inside {LS_DATA, LS_GAP};
  endproperty
  a_fd_finish: assert property (p_fd_finish) else $error("full duplex frame cut");
  property p_hd_jam;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      (state inside {LS_PREAMBLE, LS_DATA} && !fd_s && col_s) |=> state == LS_JAM;
  endproperty
  a_hd_jam: assert property (p_hd_jam) else $error("collision without jam");
  property p_jam_len;
    @(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
      $rose(state == LS_JAM) |-> (state == LS_JAM)[*8] ##1 state inside {LS_BACKOFF, LS_GAP};
  endproperty
  a_jam_len: assert property (p_jam_len) else $error("jam length wrong");
  property p_tx_dma;
    @(posedge i_clock) disable iff (!i_reset_n)
      done_edge |=> o_tx_dma_req && o_frame_ready;
  endproperty
  a_tx_dma: assert property (p_tx_dma) else $error("no tx dma request after frame");
  property p_rx_dma;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_rx_packet_received |=> o_rx_dma_req;
  endproperty
  a_rx_dma: assert property (p_rx_dma) else $error("no rx dma request");

  c_sent: cover property (@(posedge i_clock) disable iff (!i_reset_n) o_frame_sent);
  c_abort: cover property (@(posedge i_clock) disable iff (!i_reset_n) o_frame_aborted);
  c_jam: cover property (@(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
    $rose(state == LS_JAM));
  c_flow: cover property (@(posedge i_tx_nibble_clock) disable iff (!i_reset_n || !link_rst_n)
    state == LS_IDLE && go_pending && fd_s && col_s);

endmodule // mii_transmit_collision_mac

/* rtl/mtcm_pkg.sv */
// Constants and types shared by the transmit MAC and its link logic.
// Assumes a 125 MHz system clock and a free-running nibble clock from the PHY.
package mtcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // frame buffer geometry
  localparam int unsigned BUF_DEPTH = 2048;
  localparam int unsigned BUF_ADDR_W = 11;
  localparam logic [10:0] BUF_LAST_ADDR = 11'h7FF;
  localparam logic [10:0] BUF_FIRST_ADDR = 11'h000;

  ////////////////////////////////////////////////////////////////////////////
  // nibble counts on the link, each as the last count value
  localparam logic [11:0] CNT_ZERO = 12'h000;
  localparam logic [11:0] PREAMBLE_LAST_CNT = 12'h00F;
  localparam logic [11:0] JAM_LAST_CNT = 12'h007;
  localparam logic [11:0] SLOT_LAST_CNT = 12'h07F;
  localparam logic [11:0] GAP_LAST_CNT = 12'h017;

  // nibble values sent on the wire
  localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
  localparam logic [3:0] SFD_NIBBLE = 4'hD;
  localparam logic [3:0] JAM_NIBBLE = 4'h5;
  localparam logic [3:0] IDLE_NIBBLE = 4'h0;

  // retry control
  localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
  localparam logic [4:0] BACKOFF_LIMIT = 5'h0A;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [5:0] {
    LS_IDLE = 6'h01,
    LS_PREAMBLE = 6'h02,
    LS_DATA = 6'h04,
    LS_JAM = 6'h08,
    LS_BACKOFF = 6'h10,
    LS_GAP = 6'h20
  } mtcm_link_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mtcm_byte_t;

  typedef struct packed {
    logic tx_nibble_enable;
    logic tx_error_out;
    logic [3:0] tx_nibble_data;
  } mtcm_mii_tx_t;

endpackage

/* rtl/mtcm_sync.sv */
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a level or a toggle; bits are not coherent as a word.
`timescale 1ns/1ps
module mtcm_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock of the receiving domain
  input wire logic i_clock,
  // levels from another domain
  input wire logic [WIDTH-1:0] i_async,
  // synchronised levels
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  // no reset: the reset itself travels through here
  always_ff @(posedge i_clock) begin
    meta <= i_async;
    o_sync <= meta;
  end

endmodule // mtcm_sync

/* bench/mtcm_phy_model.sv */
// PHY stand-in: free-running nibble clock, nibble capture, commanded collision.
// Assumes the MAC drives its transmit pins from the clock this model makes.
`timescale 1ns/1ps
module mtcm_phy_model
  import mtcm_pkg::*;
(
  // commands from the bench
  input wire logic i_flow_stop,
  input wire logic [7:0] i_col_at,
  input wire logic [7:0] i_col_len,
  // MII pins
  input wire mtcm_mii_tx_t i_mii_tx,
  output logic o_tx_clock,
  output logic o_collision
);
  logic [3:0] log_nib [0:63];
  logic [7:0] len;
  logic [7:0] last_len;
  logic [7:0] prev_len;
  logic [7:0] bursts;
  logic [7:0] col_cnt;
  logic [7:0] err_seen;
  logic col_done;
  logic col;

  initial begin
    {len, last_len, prev_len, bursts, col_cnt, err_seen} = 48'h0;
    {col_done, col} = 2'b00;
    o_tx_clock = 1'b0;
    #37;
    forever #62.5 o_tx_clock = ~o_tx_clock;
  end

  // low unless flow stop or a collision is commanded
  assign o_collision = i_flow_stop | col;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge o_tx_clock) begin
    if (i_mii_tx.tx_error_out !== 1'b0) err_seen <= err_seen + 8'h01;
    // nibbles outside enable are ignored
    if (i_mii_tx.tx_nibble_enable === 1'b1) begin
      if (len < 8'h40) log_nib[len[5:0]] <= i_mii_tx.tx_nibble_data;
      len <= len + 8'h01;
    end else if (len != 8'h00) begin
      prev_len <= last_len;
      last_len <= len;
      bursts <= bursts + 8'h01;
      len <= 8'h00;
    end
  end

  // one collision per arming, held for a fixed number of link cycles
  always @(posedge o_tx_clock) begin
    if (i_col_at == 8'h00) begin
      col_done <= 1'b0;
      col <= 1'b0;
    end else if (!col_done && i_mii_tx.tx_nibble_enable === 1'b1 && len == i_col_at) begin
      col <= 1'b1;
      col_cnt <= i_col_len;
      col_done <= 1'b1;
    end else if (col) begin
      if (col_cnt <= 8'h01) col <= 1'b0;
      col_cnt <= col_cnt - 8'h01;
    end
  end
endmodule // mtcm_phy_model

/* bench/mii_transmit_collision_mac_tb.sv */
// Self-checking bench for the transmit MAC with a PHY model on the MII side.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module mii_transmit_collision_mac_tb;
  import mtcm_pkg::*;
  logic clock;
  logic reset_n;
  logic full_duplex;
  mtcm_byte_t frame;
  logic frame_valid;
  logic rx_packet_received;
  logic o_frame_ready, o_frame_sent, o_frame_aborted, o_tx_dma_req, o_rx_dma_req;
  logic tx_clock, collision, flow_stop;
  logic [7:0] col_at, col_len, b0, err_base;
  mtcm_mii_tx_t o_mii_tx;
  int fails = 0;
  int n_compared = 0;

  mii_transmit_collision_mac DUT (.i_clock(clock), .i_reset_n(reset_n),
    .i_full_duplex(full_duplex), .i_frame(frame), .i_frame_valid(frame_valid),
    .o_frame_ready(o_frame_ready), .o_frame_sent(o_frame_sent),
    .o_frame_aborted(o_frame_aborted), .o_tx_dma_req(o_tx_dma_req),
    .i_rx_packet_received(rx_packet_received), .o_rx_dma_req(o_rx_dma_req),
    .i_tx_nibble_clock(tx_clock), .i_collision_or_flow_stop(collision),
    .o_mii_tx(o_mii_tx));
  mtcm_phy_model PHY (.i_flow_stop(flow_stop), .i_col_at(col_at), .i_col_len(col_len),
    .i_mii_tx(o_mii_tx), .o_tx_clock(tx_clock), .o_collision(collision));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send_frame(input int n, input logic [7:0] base);
    int i;
    cmp(o_frame_ready, 1'b1);
    for (i = 0; i < n; i++) begin
      frame.data = base + 8'(i);
      frame.last = (i == n - 1);
      frame_valid = 1'b1;
      @(posedge clock);
      #1;
    end
    frame_valid = 1'b0;
  endtask

  // bounded wait for the completion pulse; ready and dma request rise with it
  task automatic wait_done();
    int k;
    for (k = 0; k < 40000; k++) begin
      @(posedge clock);
      #1;
      if (o_frame_sent === 1'b1 || o_frame_aborted === 1'b1) break;
    end
    cmp({o_frame_sent, o_frame_aborted, o_frame_ready, o_tx_dma_req}, 16'h000B);
  endtask

  // preamble, start nibble, then low nibble before high nibble of each byte
  task automatic check_frame(input int n, input logic [7:0] base);
    int i;
    cmp(PHY.last_len, 16'(16 + 2 * n));
    for (i = 0; i < 15; i++) cmp(PHY.log_nib[i], PREAMBLE_NIBBLE);
    cmp(PHY.log_nib[15], SFD_NIBBLE);
    for (i = 0; i < n; i++) cmp({PHY.log_nib[17 + 2 * i], PHY.log_nib[16 + 2 * i]}, base + 8'(i));
  endtask

  task automatic set_duplex(input logic fd);
    full_duplex = fd;
    repeat (40) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_rx();
    rx_packet_received = 1'b1;
    @(posedge clock);
    #1;
    rx_packet_received = 1'b0;
    cmp(o_rx_dma_req, 1'b1);
    @(posedge clock);
    #1;
    cmp(o_rx_dma_req, 1'b0);
  endtask

  task automatic t_plain();
    set_duplex(1'b0);
    send_frame(4, 8'hA0);
    cmp({o_frame_ready, o_tx_dma_req}, 16'h0000);
    wait_done();
    check_frame(4, 8'hA0);
    // next frame right on the completion edge, single byte
    send_frame(1, 8'h3C);
    wait_done();
    check_frame(1, 8'h3C);
  endtask

  task automatic t_collide();
    set_duplex(1'b0);
    b0 = PHY.bursts;
    col_at = 8'h14;
    col_len = 8'h04;
    send_frame(12, 8'h61);
    wait_done();
    col_at = 8'h00;
    check_frame(12, 8'h61);
    cmp(PHY.bursts - b0, 16'h0002);
    cmp({PHY.prev_len > 8'h14, PHY.prev_len < 8'h28}, 16'h0003);
  endtask

  task automatic t_flow_hold();
    set_duplex(1'b1);
    flow_stop = 1'b1;
    repeat (40) @(posedge clock);
    #1;
    b0 = PHY.bursts;
    send_frame(6, 8'h30);
    repeat (800) @(posedge clock);
    #1;
    cmp(PHY.bursts, b0);
    cmp(o_frame_ready, 1'b0);
    flow_stop = 1'b0;
    wait_done();
    check_frame(6, 8'h30);
  endtask

  task automatic t_flow_mid();
    set_duplex(1'b1);
    b0 = PHY.bursts;
    col_at = 8'h0A;
    col_len = 8'h3C;
    send_frame(12, 8'hC4);
    wait_done();
    col_at = 8'h00;
    check_frame(12, 8'hC4);
    cmp(PHY.bursts - b0, 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    full_duplex = 1'b0;
    frame = '0;
    frame_valid = 1'b0;
    rx_packet_received = 1'b0;
    flow_stop = 1'b0;
    col_at = 8'h00;
    col_len = 8'h00;
    // held past the link-side reset flops, longer than five cycles
    repeat (100) @(posedge clock);
    #1;
    cmp({o_frame_ready, o_tx_dma_req, o_rx_dma_req, o_frame_sent, o_frame_aborted,
         o_mii_tx}, 16'h0600);
    // pins are unknown on the link edges before the link reset lands
    err_base = PHY.err_seen;
    reset_n = 1'b1;
    @(posedge clock);
    #1;
    t_rx();
    t_plain();
    t_collide();
    t_flow_hold();
    t_flow_mid();
    cmp(PHY.err_seen - err_base, 16'h0000);
    print_verdict();
  end

  // the scenarios need under 100 us; allow about four times that
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
endmodule // mii_transmit_collision_mac_tb
